// file: acq_mem_asserts.sv
// Port-level checker for the acquisition memory control block
`timescale 1ns/1ps
module acq_mem_asserts (
   input wire mclk,
   input wire rst_n,
   input wire first_input_select_n,
   input wire second_input_select_n,
   input wire sum_mode,
   input wire io_segment_decode,
   input wire block_two_decode,
   input wire proc_rd_n,
   input wire write_phase_clock,
   input wire acq_write_grant,
   input wire channel_steer,
   input wire mem_chip_sel_n,
   input wire mem_out_en_n,
   input wire mem_write_n,
   input wire address_advance_clock,
   input wire odd_half_enable,
   input wire even_half_enable,
   input wire xcvr_dir_to_proc
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire win  = !(io_segment_decode | block_two_decode);
   wire idle = !acq_write_grant;
   // Outputs are registered, so each relation allows the one-cycle lag
   property p_first; (!first_input_select_n && !sum_mode) [*2] |-> !channel_steer;
   endproperty
   a_first: assert property (p_first) else $error("steer not low");
   property p_second;
      (first_input_select_n && !second_input_select_n && !sum_mode) [*2] |-> channel_steer;
   endproperty
   a_second: assert property (p_second) else $error("steer not high");
   property p_grant; acq_write_grant && $past(acq_write_grant) |->
      !mem_chip_sel_n && mem_out_en_n && odd_half_enable && even_half_enable;
   endproperty
   a_grant: assert property (p_grant) else $error("memory not given to capture");
   property p_hold; win && idle && $past(idle) |=> !idle || address_advance_clock;
   endproperty
   a_hold: assert property (p_hold) else $error("address advanced in access");
   property p_read; win && !proc_rd_n && idle && $past(idle) |=>
      !idle || (!mem_out_en_n && mem_write_n);
   endproperty
   a_read: assert property (p_read) else $error("read strobes wrong");
   property p_nowin; !win && idle && $past(idle) |=> !idle || (mem_write_n && mem_out_en_n);
   endproperty
   a_nowin: assert property (p_nowin) else $error("access outside window");
   property p_halves; idle && $past(idle) |=> !idle || !(odd_half_enable && even_half_enable);
   endproperty
   a_halves: assert property (p_halves) else $error("both halves on");
   property p_dir; idle |=> xcvr_dir_to_proc == !$past(proc_rd_n);
   endproperty
   a_dir: assert property (p_dir) else $error("direction wrong");
   property p_adv; acq_write_grant && $past(acq_write_grant) |->
      address_advance_clock == $past(write_phase_clock);
   endproperty
   a_adv: assert property (p_adv) else $error("advance clock not write phase");
endmodule // acq_mem_asserts

// file: acq_mem_map.vh
// Constants for the acquisition memory control block
`ifndef ACQ_MEM_MAP_VH
`define ACQ_MEM_MAP_VH
`define CLK_PERIOD_NS        100
`define CHAIN_DELAY_NS       100
`define RETIME_DELAY_NS      25
`define STEER_DELAY_NS       50
`define MEM_ADDR_W           11
`define MEM_DATA_W           8
`define PROC_ADDR_W          12
`define BUF_DEPTH            2
`define MODE_SINGLE          2'h0
`define MODE_SUM             2'h1
`define MODE_DUAL            2'h2
`define RANGE_FASTEST        2'h3
`define WR_IDLE              2'h0
`define WR_ARMED             2'h1
`define WR_GRANT             2'h2
`endif

// file: acquisition_memory_control.v
// Acquisition memory control: write window, channel steering, memory strobe mux
//
// Functional notes
// R1: Fastest rate: grant holds until record completes
// R2: Fastest rate: swap buffers enabled whole acquisition
// R3: First input select sets steering, channel low
// R4: Second input select resets steering, channel high
// R5: Sum mode: steer low, sum select high
// R6: Dual mode: steering clocked from data input
// R7: Range picks undelayed or delayed save clock
// R8: Delayed save clock retimed on converter edge
// R9: Min/max mode divides steering clock by two
// R10: Divider reset without enable, else toggles
// R11: Steering flop loads inverse of its input
// R12: Plain and XY modes bypass divider
// R13: Grant: chip select active, output enable off
// R14: Write phase clock drives strobe and advance
// R15: Data driven half period, write half later
// R16: Processor access needs window select low
// R17: Processor access holds address advance high
// R18: Processor read drives output enable only
// R19: Processor write strobe needs write and window
// R20: Address bit zero picks one half only
// R21: Transceiver direction follows read strobe
// R22: Two 2K halves, channels to opposite halves
// R23: Normal grant lasts one write phase period
// R24: Acquisition writes enable both halves together
// R25: No grant: processor signals drive memory
`timescale 1ns/1ps
`include "acq_mem_map.vh"

// Operation in brief
// The acquisition clocks reach this block as plain levels. Each one is
// sampled on mclk and, except delayed_save_in, its rising edge detected, so every derived event
// lags its pin by one mclk cycle. The grant, the data enable, the channel
// steering and the buffer pushes are all built from these edges.
// Limitation: a clock level must last at least one mclk cycle, or its
// edge is missed and the grant it should open or close is stretched.
// The grant hands the memory to the acquisition side for one write phase
// period per save clock, or for the whole record at the fastest rate.
// While it is low the processor strobes pass through, registered, so the
// memory sees them one mclk after the bus presents them.
// The two-entry buffer trades one cycle of latency for the ability to
// hold a word while the memory side stalls.
// Channel steering overrides act synchronously; the inverted data path
// only runs in dual-channel mode, when both overrides are released.

module acquisition_memory_control (
   input  wire                     mclk,
   input  wire                     rst_n,

   // Acquisition timing from the clock generator and delay chain
   input  wire                     pipeline_clock,
   input  wire                     converter_sample_clock,
   input  wire                     sample_save_clock,
   input  wire                     delayed_save_in,
   input  wire                     write_phase_clock,
   input  wire                     buffer_load_clock,

   // Mode and range controls
   input  wire                     range_select_lo,
   input  wire                     range_select_hi,
   input  wire                     record_complete_n,
   input  wire                     acquisition_enable,
   input  wire                     first_input_select_n,
   input  wire                     second_input_select_n,
   input  wire                     sum_mode,
   input  wire                     extreme_mode,
   input  wire                     swap_enable,
   input  wire                     swap_select,

   // Processor bus
   input  wire                     io_segment_decode,
   input  wire                     block_two_decode,
   input  wire                     proc_rd_n,
   input  wire                     proc_wr_n,
   input  wire [`PROC_ADDR_W-1:0]  proc_addr,

   // Swap register data into the two-entry buffer
   input  wire [`MEM_DATA_W-1:0]   min_data,
   input  wire [`MEM_DATA_W-1:0]   max_data,
   input  wire                     in_valid,
   output reg                      in_ready,
   input  wire                     mem_ready,

   // Steering and memory control outputs
   output reg                      acq_write_grant,
   output reg                      channel_steer,
   output reg                      sum_inputs_select,
   output reg                      mem_chip_sel_n,
   output reg                      mem_out_en_n,
   output reg                      mem_write_n,
   output reg                      address_advance_clock,
   output reg                      counter_load_n,
   output reg                      odd_half_enable,
   output reg                      even_half_enable,
   output reg                      xcvr_dir_to_proc,
   output reg                      swap_out_en,
   output reg                      mem_data_valid,
   output reg  [`MEM_DATA_W-1:0]   odd_bus_data,
   output reg  [`MEM_DATA_W-1:0]   even_bus_data,
   output reg  [`MEM_ADDR_W-1:0]   proc_mem_addr
);

   // Previous samples of the acquisition clocks, for edge detection.
   // They reset low, matching the idle level of every clock, so that
   // no false edge is seen on the first cycle after reset.
   reg  save_q;
   reg  wpc_q;
   reg  adc_q;
   reg  dsave_q;
   reg  pipe_q;
   reg  bufclk_q;
   wire save_rise = sample_save_clock & ~save_q;
   wire wpc_rise  = write_phase_clock & ~wpc_q;
   wire adc_rise  = converter_sample_clock & ~adc_q;
   wire pipeline_clock_rise = pipeline_clock & ~pipe_q;
   wire buf_rise  = buffer_load_clock & ~bufclk_q;

   wire fastest   = range_select_lo & range_select_hi;
   wire fast_rng  = range_select_hi & ~range_select_lo;
   wire window_n  = io_segment_decode | block_two_decode;    // R16

   // Write grant state
   reg  [1:0] wr_state_q;
   reg        arm_q;
   reg        dataen_q;
   reg        div_q;
   reg        steer_d;
   reg        sel_clk_q;
   reg        dsave_rt_q;
   wire       sel_clk;
   wire       sel_rise;

   always @(posedge mclk) begin
      if (!rst_n) begin
         save_q   <= 1'b0;
         wpc_q    <= 1'b0;
         adc_q    <= 1'b0;
         dsave_q  <= 1'b0;
         pipe_q   <= 1'b0;
         bufclk_q <= 1'b0;
      end else begin
         save_q   <= sample_save_clock;
         wpc_q    <= write_phase_clock;
         adc_q    <= converter_sample_clock;
         dsave_q  <= delayed_save_in;
         pipe_q   <= pipeline_clock;
         bufclk_q <= buffer_load_clock;
      end
   end

   // Self-resetting grant: armed by save clock, one write phase period long.
   // A save edge that lands while a grant is running is kept in arm_q, so
   // no write is lost when the save and write phase edges coincide. At the
   // fastest rate the grant is held until the record is complete.
   always @(posedge mclk) begin
      if (!rst_n || !acquisition_enable) begin
         wr_state_q      <= `WR_IDLE;
         acq_write_grant <= 1'b0;
         arm_q           <= 1'b0;
      end else begin
         if (save_rise)
            arm_q <= 1'b1;
         case (wr_state_q)
            `WR_IDLE: begin
               if (arm_q || save_rise)
                  wr_state_q <= `WR_ARMED;
            end
            `WR_ARMED: begin
               if (wpc_rise) begin
                  acq_write_grant <= 1'b1;
                  wr_state_q      <= `WR_GRANT;
                  arm_q           <= save_rise;
               end
            end
            `WR_GRANT: begin
               if (fastest) begin
                  if (!record_complete_n && wpc_rise) begin    // R1
                     acq_write_grant <= 1'b0;
                     wr_state_q      <= `WR_IDLE;
                  end
               end else if (wpc_rise) begin                  // R23
                  acq_write_grant <= 1'b0;
                  wr_state_q      <= `WR_IDLE;
               end
            end
            default: wr_state_q <= `WR_IDLE;
         endcase
      end
   end

   // Data enable follows grant half a pipeline period later, so the buses
   // are driven before the write strobe opens
   always @(posedge mclk) begin
      if (!rst_n)
         dataen_q <= 1'b0;
      else if (pipeline_clock_rise)
         dataen_q <= acq_write_grant;                      // R15
   end

   // Delayed save clock retimed on converter edge; the chain copy arrives
   // as a level, so it is sampled once more before the retiming edge
   always @(posedge mclk) begin
      if (!rst_n)
         dsave_rt_q <= 1'b0;
      else if (adc_rise)
         dsave_rt_q <= dsave_q;                            // R8
   end

   // The fast range steers from the undelayed save clock because pipeline
   // and converter run in phase there; every other range, the fastest included, takes the retimed copy
   assign sel_clk = fast_rng ? sample_save_clock : dsave_rt_q;   // R7

   always @(posedge mclk) begin
      if (!rst_n)
         sel_clk_q <= 1'b0;
      else
         sel_clk_q <= sel_clk;
   end
   assign sel_rise = sel_clk & ~sel_clk_q;

   // Divider held clear while idle so each acquisition starts in phase
   always @(posedge mclk) begin
      if (!rst_n || !acquisition_enable)
         div_q <= 1'b0;                                    // R10
      else if (sel_rise)
         div_q <= ~div_q;                                  // R9
   end

   always @* begin
      if (extreme_mode)
         steer_d = div_q;                                  // R9
      else
         steer_d = sel_clk_q;                              // R12
   end

   // Channel steering flop with set/reset overrides. The overrides are
   // synchronous here; sum beats first, first beats second, so the analog
   // switch never sees both sides of a conflicting request.
   always @(posedge mclk) begin
      if (!rst_n) begin
         channel_steer     <= 1'b0;
         sum_inputs_select <= 1'b0;
      end else begin
         sum_inputs_select <= sum_mode;                    // R5
         if (sum_mode)
            channel_steer <= 1'b0;                         // R5
         else if (!first_input_select_n)
            channel_steer <= 1'b0;                         // R3
         else if (!second_input_select_n)
            channel_steer <= 1'b1;                         // R4
         else if (adc_rise)
            channel_steer <= ~steer_d;                     // R6 R11
      end
   end

   // Two-entry buffer between swap registers and memory buses. Two entries
   // let a memory stall lose no word: a push and a pop may share a cycle,
   // and in_ready falls only when both entries hold data.
   reg [2*`MEM_DATA_W-1:0] buf_mem [0:`BUF_DEPTH-1];
   reg                     wr_ptr_q, rd_ptr_q;
   reg [1:0]               count_q;
   reg [1:0]               count_d;
   wire                    push = buf_rise & in_valid & (count_q != 2'h2);
   wire                    drive = dataen_q | (fastest & acquisition_enable);   // R2
   // A word leaves when the memory took the last one or none is pending
   wire                    pop  = drive & (count_q != 2'h0) & (mem_ready | ~mem_data_valid);
   wire [2*`MEM_DATA_W-1:0] head = buf_mem[rd_ptr_q];

   // Occupancy after this cycle's push and pop
   always @* begin
      case ({push, pop})
         2'b10:   count_d = count_q + 2'h1;
         2'b01:   count_d = count_q - 2'h1;
         default: count_d = count_q;
      endcase
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         wr_ptr_q       <= 1'b0;
         rd_ptr_q       <= 1'b0;
         count_q        <= 2'h0;
         in_ready       <= 1'b1;
         mem_data_valid <= 1'b0;
         odd_bus_data   <= 8'h00;
         even_bus_data  <= 8'h00;
      end else begin
         if (push) begin
            buf_mem[wr_ptr_q] <= swap_enable && swap_select ?
                                 {max_data, min_data} : {min_data, max_data};
            wr_ptr_q <= ~wr_ptr_q;
         end
         if (pop) begin
            rd_ptr_q       <= ~rd_ptr_q;
            odd_bus_data   <= head[2*`MEM_DATA_W-1:`MEM_DATA_W];   // R22
            even_bus_data  <= head[`MEM_DATA_W-1:0];
            mem_data_valid <= 1'b1;
         end else if (mem_ready)
            mem_data_valid <= 1'b0;
         count_q  <= count_d;
         in_ready <= (count_d != 2'h2);
      end
   end

   // Memory control multiplexer. The next values are chosen from the grant
   // first and registered afterwards, so every memory strobe leaves a flop
   // and cannot glitch while the grant changes sides.
   reg                     chip_sel_n_d;
   reg                     out_en_n_d;
   reg                     write_n_d;
   reg                     adv_clk_d;
   reg                     load_n_d;
   reg                     odd_en_d;
   reg                     even_en_d;
   reg                     dir_d;
   reg  [`MEM_ADDR_W-1:0]  mem_addr_d;

   always @* begin
      mem_addr_d = proc_mem_addr;
      if (acq_write_grant) begin
         chip_sel_n_d = 1'b0;                              // R13
         out_en_n_d   = 1'b1;                              // R13
         // Strobe only after data has settled
         write_n_d    = write_phase_clock | ~dataen_q;     // R14 R15
         adv_clk_d    = write_phase_clock;                 // R14
         load_n_d     = 1'b1;
         odd_en_d     = 1'b1;                              // R24
         even_en_d    = 1'b1;                              // R24
         dir_d        = 1'b0;
      end else begin
         // Processor side owns memory while grant is low
         chip_sel_n_d = window_n;                          // R25 R16
         out_en_n_d   = proc_rd_n | window_n;              // R18
         // A write is blocked while a read is also requested
         write_n_d    = proc_wr_n | window_n | ~proc_rd_n; // R19 R18
         adv_clk_d    = 1'b1;                              // R17
         load_n_d     = window_n;                          // R17
         mem_addr_d   = proc_addr[`PROC_ADDR_W-1:1];
         odd_en_d     = ~window_n & proc_addr[0];          // R20
         even_en_d    = ~window_n & ~proc_addr[0];         // R20
         dir_d        = ~proc_rd_n;                        // R21
      end
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         mem_chip_sel_n        <= 1'b1;
         mem_out_en_n          <= 1'b1;
         mem_write_n           <= 1'b1;
         address_advance_clock <= 1'b1;
         counter_load_n        <= 1'b1;
         odd_half_enable       <= 1'b0;
         even_half_enable      <= 1'b0;
         xcvr_dir_to_proc      <= 1'b0;
         swap_out_en           <= 1'b0;
         proc_mem_addr         <= 11'h000;
      end else begin
         swap_out_en           <= drive;                   // R2 R15
         mem_chip_sel_n        <= chip_sel_n_d;
         mem_out_en_n          <= out_en_n_d;
         mem_write_n           <= write_n_d;
         address_advance_clock <= adv_clk_d;
         counter_load_n        <= load_n_d;
         odd_half_enable       <= odd_en_d;
         even_half_enable      <= even_en_d;
         xcvr_dir_to_proc      <= dir_d;
         proc_mem_addr         <= mem_addr_d;
      end
   end

endmodule // acquisition_memory_control

// file: acquisition_memory_control_tb.sv
// Self-checking bench for the acquisition memory control block
`timescale 1ns/1ps
`include "acq_mem_map.vh"
module acquisition_memory_control_tb;
   logic mclk, rst_n, pipeline_clock, converter_sample_clock, sample_save_clock;
   logic delayed_save_in, write_phase_clock, buffer_load_clock, range_select_lo;
   logic range_select_hi, record_complete_n, acquisition_enable, first_input_select_n;
   logic second_input_select_n, sum_mode, extreme_mode, swap_enable, swap_select;
   logic io_segment_decode, block_two_decode, proc_rd_n, proc_wr_n, in_valid, in_ready;
   logic mem_ready, acq_write_grant, channel_steer, sum_inputs_select, mem_chip_sel_n;
   logic mem_out_en_n, mem_write_n, address_advance_clock, counter_load_n, odd_half_enable;
   logic even_half_enable, xcvr_dir_to_proc, swap_out_en, mem_data_valid, run, stall;
   logic [`PROC_ADDR_W-1:0] proc_addr;
   logic [`MEM_DATA_W-1:0]  min_data, max_data, odd_bus_data, even_bus_data;
   logic [`MEM_ADDR_W-1:0]  proc_mem_addr;
   logic [7:0]              words_taken;
   logic [15:0]             last_word;
   logic [3:0]              ph;
   int                      miscompares, num_checks, cyc, n;
   // Slow acquisition clocks as whole mclk multiples: write phase period is 4 cycles
   assign pipeline_clock         = ph[0];
   assign converter_sample_clock = ph[0];
   assign write_phase_clock      = ph[1];
   assign buffer_load_clock      = ph[1];
   assign sample_save_clock      = ph[3];
   acquisition_memory_control i_dut (.*);
   mem_side_model i_mem (.mclk(mclk), .rst_n(rst_n), .stall(stall),
      .mem_data_valid(mem_data_valid), .odd_bus_data(odd_bus_data),
      .even_bus_data(even_bus_data), .mem_ready(mem_ready), .words_taken(words_taken),
      .last_word(last_word));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      ph <= run ? ph + 4'h1 : 4'h0;
      delayed_save_in <= sample_save_clock;
      cyc = cyc + 1;
      if (cyc == 3000) begin
         miscompares = miscompares + 1;
         report_and_stop();
      end
   end
   task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         miscompares = miscompares + 1;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task tick;
      @(posedge mclk);
      #1;
   endtask
   // sel is {io_segment_decode, block_two_decode, proc_rd_n, proc_wr_n}
   task proc(input logic [3:0] sel, input logic [11:0] adr, input logic [6:0] exp);
      @(posedge mclk);
      {io_segment_decode, block_two_decode, proc_rd_n, proc_wr_n} <= sel;
      proc_addr <= adr;
      repeat (2) tick();
      chk("proc strobes", {9'h000, exp}, {9'h000, mem_out_en_n, mem_write_n, odd_half_enable,
         even_half_enable, xcvr_dir_to_proc, counter_load_n, address_advance_clock});
      if (!exp[1]) chk("load addr", {5'h00, adr[11:1]}, {5'h00, proc_mem_addr});
      @(posedge mclk);
      {io_segment_decode, block_two_decode, proc_rd_n, proc_wr_n} <= 4'hF;
   endtask
   logic [2:0] chan_in [4] = '{3'h2, 3'h4, 3'h7, 3'h0};
   logic [1:0] chan_exp [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
   initial begin
      {rst_n, run, stall, in_valid, acquisition_enable, sum_mode, extreme_mode} = 7'h00;
      {swap_enable, swap_select, range_select_lo, range_select_hi} = 4'h0;
      {io_segment_decode, block_two_decode, proc_rd_n, proc_wr_n} = 4'hF;
      {record_complete_n, first_input_select_n, second_input_select_n} = 3'h7;
      {proc_addr, min_data, max_data} = {12'h000, 8'h3C, 8'hC3};
      {miscompares, num_checks, cyc} = 0;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (2) tick();
      chk("idle state", 16'h007C, {8'h00, acq_write_grant, address_advance_clock, mem_write_n,
         mem_out_en_n, mem_chip_sel_n, in_ready, odd_half_enable, even_half_enable});
      $display("test reset done");
      proc(4'h1, 12'hA5B, 7'h35);
      proc(4'h2, 12'h5A4, 7'h49);
      proc(4'h5, 12'hA5B, 7'h67);
      proc(4'hA, 12'h5A4, 7'h63);
      $display("test processor access done");
      for (int k = 0; k < 4; k++) begin
         @(posedge mclk);
         {first_input_select_n, second_input_select_n, sum_mode} <= chan_in[k];
         repeat (2) tick();
         chk("steer", {14'h0000, chan_exp[k]}, {14'h0000, channel_steer, sum_inputs_select});
      end
      $display("test channel select done");
      @(posedge mclk);
      {first_input_select_n, second_input_select_n, sum_mode} <= 3'h6;
      {run, acquisition_enable, stall, in_valid} <= 4'hF;
      for (n = 0; acq_write_grant !== 1'b1 && n < 100; n++) tick();
      for (n = 0; acq_write_grant === 1'b1 && n < 20; n++) tick();
      chk("grant length", 16'h0004, n[15:0]);
      for (n = 0; in_ready !== 1'b0 && n < 100; n++) tick();
      chk("stalled fill", 16'h0000, {7'h00, in_ready, words_taken});
      @(posedge mclk);
      stall <= 1'b0;
      for (n = 0; words_taken < 8'h02 && n < 200; n++) tick();
      chk("word pair", {min_data, max_data}, last_word);
      chk("drained", 16'h0001, {15'h0000, words_taken >= 8'h02});
      $display("test normal capture done");
      @(posedge mclk);
      {acquisition_enable, range_select_lo, range_select_hi} <= 3'h3;
      @(posedge mclk);
      acquisition_enable <= 1'b1;
      for (n = 0; acq_write_grant !== 1'b1 && n < 100; n++) tick();
      for (n = 0; acq_write_grant === 1'b1 && n < 40; n++) tick();
      chk("grant held", 16'h0028, n[15:0]);
      chk("swap out", 16'h0001, {15'h0000, swap_out_en});
      @(posedge mclk);
      record_complete_n <= 1'b0;
      for (n = 0; acq_write_grant === 1'b1 && n < 20; n++) tick();
      chk("grant end", 16'h0001, {15'h0000, n < 8});
      $display("test fastest capture done");
      report_and_stop();
   end
endmodule // acquisition_memory_control_tb
bind acquisition_memory_control acq_mem_asserts i_chk (.*);

// file: mem_side_model.sv
// Behavioural memory side that takes buffered word pairs and can stall
`timescale 1ns/1ps
module mem_side_model (
   input  wire        mclk,
   input  wire        rst_n,
   input  wire        stall,
   input  wire        mem_data_valid,
   input  wire [7:0]  odd_bus_data,
   input  wire [7:0]  even_bus_data,
   output wire        mem_ready,
   output reg  [7:0]  words_taken,
   output reg  [15:0] last_word
);
   assign mem_ready = !stall;
   always @(posedge mclk) begin
      if (!rst_n) begin
         words_taken <= 8'h00;
         last_word   <= 16'h0000;
      end else if (mem_data_valid && mem_ready) begin
         words_taken <= words_taken + 8'h01;
         last_word   <= {odd_bus_data, even_bus_data};
      end
   end
endmodule // mem_side_model
